/* File: clock_power_config_regs.sv */
/*
 * Clock and power configuration register bank: power mode select,
 * timestamp input control, reference output control, synthesizer
 * feedback dividers and oscillator bias.
 * Assumes the serial control port logic delivers one-cycle write and
 * read strobes with an 8-bit address on the same clock.
 */
// Functional notes
// - Timestamp bit 0 turns receiver on
// - Timestamp bit 1 selects PECL input mode
// - Reference output on with synthesizer, resets on
// - Second divider codes give 1, 2, 4
// - First divider codes give 5, 4, 3
// - First divider output feeds second divider
// - Third divider divides by value 1..63
// - Third divider makes the PFD feedback clock
`timescale 1ns/1ps
`default_nettype none
`include "clock_power_params.svh"

module clock_power_config_regs (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire logic                          clk_en,
    // Serial control port register access
    input  wire logic [7:0]                    reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_rd,
    output logic [7:0]                         reg_rdata,
    output logic                               reg_hit,
    // Device state used by the outputs
    input  wire logic                          synth_enable,
    // Power mode
    output logic [7:0]                         power_mode_code,
    output var   clock_power_pkg::power_mode_e power_mode,
    // Timestamp input
    output logic                               stamp_receiver_on,
    output logic                               stamp_input_pecl_mode,
    // Reference clock output
    output logic                               ref_output_on,
    output logic                               ref_output_active,
    // Synthesizer feedback chain
    output var   clock_power_pkg::ratio_t      div_v_ratio,
    output var   clock_power_pkg::ratio_t      div_p_ratio,
    output logic [5:0]                         div_n_ratio,
    output logic [11:0]                        loop_ratio,
    output logic                               div_setting_valid,
    // Oscillator bias
    output logic [6:0]                         oscillator_bias
);

    ////////////////////////////////////////////////////////////////////
    // Register storage, one byte per register
    localparam int NREG = 6;

    // Index of each register in the storage array, in address order;
    // the names keep the field slices below readable
    localparam int IDX_POWER  = 0;
    localparam int IDX_STAMP  = 1;
    localparam int IDX_REFOUT = 2;
    localparam int IDX_DIV_A  = 3;
    localparam int IDX_DIV_B  = 4;
    localparam int IDX_BIAS   = 5;

    clock_power_pkg::reg_byte_t regs_r   [NREG];
    clock_power_pkg::reg_byte_t regs_nxt [NREG];
    logic [NREG-1:0]            sel;
    logic [7:0]                 rdata_r;
    logic [7:0]                 rdata_nxt;
    logic                       hit_r;
    logic                       hit_nxt;
    logic                       wr_take;
    logic                       rd_take;
    logic [1:0]                 div_v_code;
    logic [1:0]                 div_p_code;
    logic [5:0]                 div_n_value;

    // Address to register index; decoded for both write and read paths.
    // At most one bit set, since the offsets are all distinct; an unmapped address sets none
    function automatic logic [NREG-1:0] decode(input logic [7:0] a);
        logic [NREG-1:0] d;
        d             = '0;
        d[IDX_POWER]  = (a == `OFS_POWER_MODE_SELECT);
        d[IDX_STAMP]  = (a == `OFS_TIMESTAMP_CTRL);
        d[IDX_REFOUT] = (a == `OFS_REF_OUTPUT_CTRL);
        d[IDX_DIV_A]  = (a == `OFS_SYNTH_DIV_A);
        d[IDX_DIV_B]  = (a == `OFS_SYNTH_DIV_B);
        d[IDX_BIAS]   = (a == `OFS_OSC_BIAS_CTRL);
        return d;
    endfunction

    // Reset value per register index, reserved bits included
    function automatic logic [7:0] reset_value(input int idx);
        case (idx)
            IDX_POWER:  return `RST_POWER_MODE_SELECT;
            IDX_STAMP:  return `RST_TIMESTAMP_CTRL;
            IDX_REFOUT: return `RST_REF_OUTPUT_CTRL;
            IDX_DIV_A:  return `RST_SYNTH_DIV_A;
            IDX_DIV_B:  return `RST_SYNTH_DIV_B;
            default:    return `RST_OSC_BIAS_CTRL;
        endcase
    endfunction

    assign sel = decode(reg_addr);

    // Accesses only count while the clock enable lets state move; reset
    // is left out on purpose so a frozen bank still comes up in defaults
    assign wr_take = clk_en && reg_wr;
    assign rd_take = clk_en && reg_rd;

    ////////////////////////////////////////////////////////////////////
    // Write path: every bit stored as written, reserved ones included,
    // so software sees back exactly what it wrote; no code is filtered.
    // Reset is tested first, so a write during reset is lost, and an
    // unmapped write matches no select line and is dropped
    generate
        for (genvar i = 0; i < NREG; i++) begin : g_reg
            always_comb begin
                regs_nxt[i] = regs_r[i];
                if (rst) begin
                    regs_nxt[i] = reset_value(i);
                end else if (wr_take && sel[i]) begin
                    regs_nxt[i] = reg_wdata;
                end
            end

            always_ff @(posedge clock) begin
                regs_r[i] <= regs_nxt[i];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Read path: registered data; unmapped addresses read zero.
    // The byte holds until the next taken read, so the port may fetch
    // it late; a read in the same cycle as a write to that byte sees
    // the old value, since the mux looks at the stored copy
    always_comb begin
        rdata_nxt = rdata_r;
        hit_nxt   = hit_r;
        if (rst) begin
            rdata_nxt = 8'h00;
            hit_nxt   = 1'b0;
        end else if (rd_take) begin
            rdata_nxt = 8'h00;
            for (int k = 0; k < NREG; k++) begin
                if (sel[k]) begin
                    rdata_nxt = regs_r[k];
                end
            end
            hit_nxt = |sel;
        end
    end

    always_ff @(posedge clock) begin
        rdata_r <= rdata_nxt;
        hit_r   <= hit_nxt;
    end

    assign reg_rdata = rdata_r;
    assign reg_hit   = hit_r;

    ////////////////////////////////////////////////////////////////////
    // Power mode: the raw code drives the analog; reserved codes are
    // flagged rather than blocked, since software owns the sequence.
    // The calibration and link enables live in other registers, so the
    // order of a mode change cannot be checked from here
    assign power_mode_code = regs_r[IDX_POWER];

    always_comb begin
        case (regs_r[IDX_POWER])
            `PWR_CODE_LOW_POWER: power_mode = clock_power_pkg::PWR_LOW_POWER;
            `PWR_CODE_HIGH_PERF: power_mode = clock_power_pkg::PWR_HIGH_PERF;
            default:             power_mode = clock_power_pkg::PWR_RESERVED;
        endcase
    end

    // Timestamp receiver enable and input mode; bits 7:2 steer nothing
    assign stamp_receiver_on     = regs_r[IDX_STAMP][`BIT_STAMP_RECEIVER_ON];
    assign stamp_input_pecl_mode = regs_r[IDX_STAMP][`BIT_STAMP_PECL_MODE];

    // Reference output follows the synthesizer enable when allowed;
    // it resets on because the host may derive its port clock from it
    assign ref_output_on     = regs_r[IDX_REFOUT][`BIT_REF_OUTPUT_ON];
    assign ref_output_active = ref_output_on && synth_enable;

    // Oscillator bias field; it comes up at its reset code, so software
    // must load the working code before the synthesizer is relied on
    assign oscillator_bias = regs_r[IDX_BIAS][`FLD_BIAS_HI:`FLD_BIAS_LO];

    ////////////////////////////////////////////////////////////////////
    // Feedback chain decode: first divider, then second, then third.
    // The reserved upper bits stay stored for read-back but steer nothing
    assign div_v_code  = regs_r[IDX_DIV_A][`FLD_DIV_V_HI:`FLD_DIV_V_LO];
    assign div_p_code  = regs_r[IDX_DIV_A][`FLD_DIV_P_HI:`FLD_DIV_P_LO];
    assign div_n_value = regs_r[IDX_DIV_B][`FLD_DIV_N_HI:`FLD_DIV_N_LO];

    feedback_div_decode u_div (
        .div_v_code        (div_v_code),
        .div_p_code        (div_p_code),
        .div_n_value       (div_n_value),
        .div_v_ratio       (div_v_ratio),
        .div_p_ratio       (div_p_ratio),
        .div_n_ratio       (div_n_ratio),
        .loop_ratio        (loop_ratio),
        .div_setting_valid (div_setting_valid)
    );

endmodule
`default_nettype wire

/* File: clock_power_params.svh */
/*
 * Constants for the clock and power configuration register bank:
 * register offsets, field positions, reset values and divider codes.
 * Assumes it is included by bare name from the register bank files.
 */
`ifndef CLOCK_POWER_PARAMS_SVH
`define CLOCK_POWER_PARAMS_SVH

// Register offsets on the serial control port
`define OFS_POWER_MODE_SELECT   8'h37
`define OFS_TIMESTAMP_CTRL      8'h3B
`define OFS_REF_OUTPUT_CTRL     8'h3C
`define OFS_SYNTH_DIV_A         8'h3D
`define OFS_SYNTH_DIV_B         8'h3E
`define OFS_OSC_BIAS_CTRL       8'h3F

// Reset values
`define RST_POWER_MODE_SELECT   8'h4B
`define RST_TIMESTAMP_CTRL      8'h00
`define RST_REF_OUTPUT_CTRL     8'h01
`define RST_SYNTH_DIV_A         8'h00
`define RST_SYNTH_DIV_B         8'h20
`define RST_OSC_BIAS_CTRL       8'h4F

// Power mode codes
`define PWR_CODE_LOW_POWER      8'h46
`define PWR_CODE_HIGH_PERF      8'h4B

// Field positions
`define BIT_STAMP_RECEIVER_ON   0
`define BIT_STAMP_PECL_MODE     1
`define BIT_REF_OUTPUT_ON       0
`define FLD_DIV_V_HI            1
`define FLD_DIV_V_LO            0
`define FLD_DIV_P_HI            3
`define FLD_DIV_P_LO            2
`define FLD_DIV_N_HI            5
`define FLD_DIV_N_LO            0
`define FLD_BIAS_HI             6
`define FLD_BIAS_LO             0

// Divider ratios selected by the two-bit codes
`define DIV_V_CODE0_RATIO       3'h5
`define DIV_V_CODE1_RATIO       3'h4
`define DIV_V_CODE2_RATIO       3'h3
`define DIV_P_CODE0_RATIO       3'h1
`define DIV_P_CODE1_RATIO       3'h2
`define DIV_P_CODE2_RATIO       3'h4
`define DIV_RESERVED_RATIO      3'h0

`endif

/* File: clock_power_pkg.sv */
/*
 * Types shared by the clock and power configuration register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package clock_power_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [2:0] ratio_t;
    typedef enum logic [1:0] {
        PWR_HIGH_PERF = 2'h0,
        PWR_LOW_POWER = 2'h1,
        PWR_RESERVED  = 2'h3
    } power_mode_e;
endpackage

/* File: feedback_div_decode.sv */
/*
 * Decodes the synthesizer feedback divider fields into ratios and
 * the total loop ratio of the feedback chain.
 * Assumes the fields come straight from the register flip-flops.
 */
`timescale 1ns/1ps
`default_nettype none
`include "clock_power_params.svh"

module feedback_div_decode (
    // Divider fields
    input  wire logic [1:0]                div_v_code,
    input  wire logic [1:0]                div_p_code,
    input  wire logic [5:0]                div_n_value,
    // Decoded ratios
    output var   clock_power_pkg::ratio_t  div_v_ratio,
    output var   clock_power_pkg::ratio_t  div_p_ratio,
    output logic [5:0]                     div_n_ratio,
    output logic [11:0]                    loop_ratio,
    output logic                           div_setting_valid
);

    ////////////////////////////////////////////////////////////////////
    // First divider: codes 0,1,2 give 5,4,3; code 3 reads as zero
    always_comb begin
        case (div_v_code)
            2'h0:    div_v_ratio = `DIV_V_CODE0_RATIO;
            2'h1:    div_v_ratio = `DIV_V_CODE1_RATIO;
            2'h2:    div_v_ratio = `DIV_V_CODE2_RATIO;
            default: div_v_ratio = `DIV_RESERVED_RATIO;
        endcase
    end

    // Second divider: codes 0,1,2 give 1,2,4; its output is the sample clock
    always_comb begin
        case (div_p_code)
            2'h0:    div_p_ratio = `DIV_P_CODE0_RATIO;
            2'h1:    div_p_ratio = `DIV_P_CODE1_RATIO;
            2'h2:    div_p_ratio = `DIV_P_CODE2_RATIO;
            default: div_p_ratio = `DIV_RESERVED_RATIO;
        endcase
    end

    // Third divider divides by its own value; zero is unsupported
    assign div_n_ratio = div_n_value;

    // Chain: first feeds second, second feeds third, third feeds the PFD
    // Each factor is widened first so the product cannot wrap at six bits
    assign loop_ratio = 12'(div_v_ratio) * 12'(div_p_ratio) * 12'(div_n_ratio);

    // A reserved code anywhere makes the chain setting invalid
    assign div_setting_valid = (div_v_ratio != `DIV_RESERVED_RATIO)
                            && (div_p_ratio != `DIV_RESERVED_RATIO)
                            && (div_n_value != 6'h00);

endmodule
`default_nettype wire

/* File: clock_power_config_regs_properties.sv */
/*
 * Checker for the clock and power configuration register bank.
 * Assumes it is bound to clock_power_config_regs and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module clock_power_config_regs_properties (
    // Clock, reset and access
    input wire logic                     clock,
    input wire logic                     rst,
    input wire logic                     clk_en,
    input wire logic [7:0]               reg_addr,
    input wire logic                     reg_wr,
    input wire logic [7:0]               reg_wdata,
    input wire logic                     reg_rd,
    input wire logic [7:0]               reg_rdata,
    input wire logic                     reg_hit,
    input wire logic                     synth_enable,
    // Field outputs
    input wire logic [7:0]               power_mode_code,
    input wire logic                     stamp_receiver_on,
    input wire logic                     stamp_input_pecl_mode,
    input wire logic                     ref_output_on,
    input wire logic                     ref_output_active,
    input wire clock_power_pkg::ratio_t  div_v_ratio,
    input wire clock_power_pkg::ratio_t  div_p_ratio,
    input wire logic [5:0]               div_n_ratio,
    input wire logic [11:0]              loop_ratio,
    input wire logic [6:0]               oscillator_bias
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic wt;
    // A write only counts while the clock enable lets state move
    assign wt = reg_wr && clk_en;
    chk_recv_bit: assert property (wt && reg_addr == 8'h3B |=>
        stamp_receiver_on == $past(reg_wdata[0])) else $error("receiver bit");
    chk_pecl_bit: assert property (wt && reg_addr == 8'h3B |=>
        stamp_input_pecl_mode == $past(reg_wdata[1])) else $error("pecl bit");
    chk_ref_gate: assert property (
        ref_output_active == (ref_output_on && synth_enable)) else $error("ref gating");
    chk_p_decode: assert property (wt && reg_addr == 8'h3D |=> div_p_ratio ==
        (($past(reg_wdata[3:2]) == 2'h3) ? 3'h0 : (3'h1 << $past(reg_wdata[3:2]))))
        else $error("p decode");
    chk_v_decode: assert property (wt && reg_addr == 8'h3D |=> div_v_ratio ==
        (($past(reg_wdata[1:0]) == 2'h3) ? 3'h0 : 3'h5 - 3'($past(reg_wdata[1:0]))))
        else $error("v decode");
    chk_loop_chain: assert property (loop_ratio ==
        12'(div_v_ratio) * 12'(div_p_ratio) * 12'(div_n_ratio)) else $error("loop ratio");
    chk_n_direct: assert property (wt && reg_addr == 8'h3E |=>
        div_n_ratio == $past(reg_wdata[5:0])) else $error("n value");
    chk_bias_store: assert property (wt && reg_addr == 8'h3F |=>
        oscillator_bias == $past(reg_wdata[6:0])) else $error("bias value");
    chk_read_back: assert property (reg_rd && clk_en && reg_addr == 8'h37 |=>
        reg_hit && reg_rdata == $past(power_mode_code)) else $error("read back");
    chk_read_miss: assert property (reg_rd && clk_en && reg_addr == 8'h00 |=>
        !reg_hit && reg_rdata == 8'h00) else $error("unmapped read");
    chk_freeze_hold: assert property (!clk_en |=> $stable(reg_rdata)
        && $stable(reg_hit) && $stable(power_mode_code) && $stable(oscillator_bias))
        else $error("frozen state moved");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind clock_power_config_regs clock_power_config_regs_properties chk (.clock, .rst, .clk_en,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_hit, .synth_enable,
    .power_mode_code, .stamp_receiver_on, .stamp_input_pecl_mode, .ref_output_on,
    .ref_output_active, .div_v_ratio, .div_p_ratio, .div_n_ratio, .loop_ratio,
    .oscillator_bias);
`default_nettype wire

/* File: clock_power_config_regs_bench.sv */
/*
 * Self-checking bench for the clock and power configuration register bank.
 * Assumes one-cycle strobes and the fixed read latency of the port.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("[ERR] %0t mismatch got %h want %h", $time, (a), (b)); end end
module clock_power_config_regs_bench;
    logic                     clock = 1'b0, rst = 1'b1, clk_en = 1'b1;
    logic                     reg_wr = 1'b0, reg_rd = 1'b0, synth_enable = 1'b0;
    logic [7:0]               reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, power_mode_code;
    logic                     reg_hit, stamp_receiver_on, stamp_input_pecl_mode;
    logic                     ref_output_on, ref_output_active, div_setting_valid;
    clock_power_pkg::power_mode_e power_mode;
    clock_power_pkg::ratio_t  div_v_ratio, div_p_ratio, ev, ep;
    logic [5:0]               div_n_ratio;
    logic [11:0]              loop_ratio;
    logic [6:0]               oscillator_bias;
    logic [7:0]               ra [6] = '{8'h37, 8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F};
    logic [7:0]               rv [6] = '{8'h4B, 8'h00, 8'h01, 8'h00, 8'h20, 8'h4F};
    int                       err_total = 0, check_count = 0;
    // 40 MHz clock
    always #12.5 clock = ~clock;
    clock_power_config_regs dut (.clock, .rst, .clk_en, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .reg_hit, .synth_enable, .power_mode_code, .power_mode,
        .stamp_receiver_on, .stamp_input_pecl_mode, .ref_output_on, .ref_output_active,
        .div_v_ratio, .div_p_ratio, .div_n_ratio, .loop_ratio, .div_setting_valid,
        .oscillator_bias);
    ////////////////////////////////////////////////////////////////////////////
    // Write strobe for one cycle; returns once the edge has landed
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask
    // Read strobe, then compare data and hit flag
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
        @(posedge clock);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
        `CHK(reg_hit, h)
    endtask
    task automatic final_report;
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) rd(ra[i], rv[i], 1'b1);
        `CHK(ref_output_on, 1'b1)
        `CHK(loop_ratio, 12'h0A0)
        rd(8'h00, 8'h00, 1'b0);
        wr(8'h37, 8'h46);
        `CHK(power_mode, clock_power_pkg::PWR_LOW_POWER)
        `CHK(power_mode_code, 8'h46)
        wr(8'h37, 8'h4B);
        `CHK(power_mode, clock_power_pkg::PWR_HIGH_PERF)
        rd(8'h37, 8'h4B, 1'b1);
        wr(8'h3B, 8'h03);
        `CHK({stamp_input_pecl_mode, stamp_receiver_on}, 2'h3)
        wr(8'h3B, 8'h01);
        `CHK({stamp_input_pecl_mode, stamp_receiver_on}, 2'h1)
        `CHK(ref_output_active, 1'b0)
        @(posedge clock);
        synth_enable <= 1'b1;
        wr(8'h3C, 8'h00);
        `CHK(ref_output_active, 1'b0)
        wr(8'h3C, 8'h01);
        `CHK(ref_output_active, 1'b1)
        // Every code pair of the first and second dividers, n at 32
        for (int c = 0; c < 16; c++) begin
            wr(8'h3D, 8'(c));
            ev = (c % 4 == 3) ? 3'h0 : 3'(5 - c % 4);
            ep = (c / 4 == 3) ? 3'h0 : 3'(1 << (c / 4));
            `CHK(div_v_ratio, ev)
            `CHK(div_p_ratio, ep)
            `CHK(loop_ratio, 12'(ev * ep * 32))
            `CHK(div_setting_valid, (ev != 3'h0 && ep != 3'h0))
        end
        wr(8'h3D, 8'h00);
        // Third divider at its top value 63 and at zero
        for (int n = 0; n < 64; n += 63) begin
            wr(8'h3E, 8'(n));
            `CHK(div_n_ratio, 6'(n))
            `CHK(loop_ratio, 12'(5 * n))
            `CHK(div_setting_valid, (n != 0))
        end
        wr(8'h3F, 8'h4A);
        `CHK(oscillator_bias, 7'h4A)
        // Frozen clock enable must drop the write
        @(posedge clock);
        clk_en <= 1'b0;
        wr(8'h3F, 8'h11);
        @(posedge clock);
        clk_en <= 1'b1;
        rd(8'h3F, 8'h4A, 1'b1);
        wr(8'h3C, 8'h00);
        // Second reset brings the defaults back
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        rd(8'h3E, 8'h20, 1'b1);
        rd(8'h3C, 8'h01, 1'b1);
        `CHK(ref_output_active, 1'b1)
        final_report();
    end
endmodule
`default_nettype wire
